// ### hw/mclr_digest_check.sv
// Compares the computed program store digest with the expected value.
// Assumes the digest engine gives a one-cycle done pulse with its result.
`timescale 1ns/1ns
`default_nettype none
module mclr_digest_check (
   // Clock and reset
   input  wire logic                 mclk_in,
   input  wire logic                 rst_n_in,
   // Engine result
   input  wire logic                 done_in,
   input  wire logic [31:0]          computed_in,
   // Expected value
   input  wire logic [15:0]          expect_high_in,
   input  wire logic [15:0]          expect_low_in,
   // Verdict, one cycle after done
   output var mclr_pkg::mclr_chk_type result_out
);
   logic mismatch_nxt;

   // both halves must agree with the stored expectation.
   always_comb begin
      mismatch_nxt = (computed_in != {expect_high_in, expect_low_in});
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         result_out <= mclr_pkg::MCLR_CHK_NONE;
      end else if (done_in) begin
         result_out <= mismatch_nxt ? mclr_pkg::MCLR_CHK_FAIL : mclr_pkg::MCLR_CHK_PASS;
      end else begin
         result_out <= mclr_pkg::MCLR_CHK_NONE;
      end
   end
endmodule
`default_nettype wire

// ### hw/mclr_dual_field.sv
// Eight-bit field that acts as host control bits or as core status bits.
// Assumes the role select comes from the converter split configuration.
`timescale 1ns/1ns
`default_nettype none
module mclr_dual_field (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   // Role select, high for status role
   input  wire logic       status_role_in,
   // Host write
   input  wire logic       host_wr_in,
   input  wire logic [7:0] host_data_in,
   // Core bit instructions
   input  wire logic       core_set_in,
   input  wire logic       core_clr_in,
   input  wire logic [2:0] core_idx_in,
   // Field value
   output logic [7:0]      field_out
);
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_bit
         logic hit;
         assign hit = (core_idx_in == 3'(b));
         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               field_out[b] <= 1'b0;
            end else if (status_role_in) begin
               // Host writes do nothing here; a set beats a clear of the same bit.
               if (core_set_in && hit) begin
                  field_out[b] <= 1'b1;
               end else if (core_clr_in && hit) begin
                  field_out[b] <= 1'b0;
               end
            end else if (host_wr_in) begin
               field_out[b] <= host_data_in[b];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### hw/mclr_pkg.sv
// Constants shared by the microcode lock and control register block.
// Assumes one channel at the first channel base address.
package mclr_pkg;
   localparam int         ADDR_W             = 10;
   localparam int         DATA_W             = 16;
   localparam int         FIELD_W            = 8;
   localparam int         DIGEST_W           = 32;
   // Register offsets.
   localparam logic [9:0] CODE_PROTECT_OFS   = 10'h100;
   localparam logic [9:0] CORE0_COMMAND_OFS  = 10'h101;
   localparam logic [9:0] DIGEST_HIGH_OFS    = 10'h108;
   localparam logic [9:0] DIGEST_LOW_OFS     = 10'h109;
   // Field positions in code_protect_config.
   localparam int         MISMATCH_BIT       = 0;
   localparam int         ALERT_EN_BIT       = 1;
   localparam int         PAIRED_BIT         = 3;
   localparam int         FREEZE_BIT         = 4;
   localparam int         RUN_PERMIT_BIT     = 5;
   localparam int         OVERRIDE_BIT       = 6;
   // Field positions in core0_command.
   localparam int         CMD_LSB            = 0;
   localparam int         DUAL_LSB           = 8;
   // Reset values.
   localparam logic [15:0] CODE_PROTECT_RST  = 16'h0000;
   localparam logic [7:0]  FIELD_RST         = 8'h00;
   localparam logic [15:0] DIGEST_RST        = 16'h0000;
   // Freeze release key; the value is arbitrary.
   localparam logic [15:0] RELEASE_KEY       = 16'h5a3c;
   // Divider values below this restrict memory access in paired mode.
   localparam logic [3:0]  DIVIDER_MIN_FULL  = 4'h3;
   // Digest check result encoding.
   typedef enum logic [1:0] {
      MCLR_CHK_NONE,
      MCLR_CHK_PASS,
      MCLR_CHK_FAIL
   } mclr_chk_type;
endpackage

// ### hw/mclr_top.sv
// Per-channel code protection and core command registers.
// Assumes a decoded SPI word port, an external digest engine and
// microcores that read the command bits directly.
`timescale 1ns/1ns
`default_nettype none
module mclr_top (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   // Host register port
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [9:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic [15:0]      reg_rdata_out,
   output logic             reg_rvalid_out,
   // Freeze release key
   input  wire logic        key_wr_in,
   input  wire logic [15:0] key_data_in,
   // Program store write gate
   input  wire logic        store_wr_req_in,
   output logic             store_wr_grant_out,
   output logic             store_wr_reject_out,
   // Digest engine
   output logic             digest_start_out,
   input  wire logic        digest_done_in,
   input  wire logic [31:0] digest_value_in,
   // Microcore side
   input  wire logic        dual_role_status_in,
   input  wire logic        core_set_bit_in,
   input  wire logic        core_clr_bit_in,
   input  wire logic [2:0]  core_bit_index_in,
   input  wire logic [3:0]  core_clock_divider_in,
   output logic [7:0]       core_command_out,
   output logic [7:0]       dual_role_out,
   output logic             core_run_out,
   output logic             paired_core_mode_out,
   output logic             access_restricted_out,
   // Interrupt
   output logic             irq_out
);
   logic [15:0]            protect_r;
   logic [7:0]             command_r;
   logic [15:0]            digest_high_r;
   logic [15:0]            digest_low_r;
   logic                   freeze_d_r;
   logic                   fail_seen_r;
   logic                   wr_protect;
   logic                   wr_command;
   logic                   key_ok;
   logic                   freeze_rise;
   logic [15:0]            rdata_nxt;
   mclr_pkg::mclr_chk_type chk_result;

   assign wr_protect = reg_wr_in && (reg_addr_in == mclr_pkg::CODE_PROTECT_OFS);
   assign wr_command = reg_wr_in && (reg_addr_in == mclr_pkg::CORE0_COMMAND_OFS);
   assign key_ok     = key_wr_in && (key_data_in == mclr_pkg::RELEASE_KEY);
   assign freeze_rise = protect_r[mclr_pkg::FREEZE_BIT] && !freeze_d_r;

   // Freeze bit: settable by the host, locked by itself until the key is given.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         protect_r[mclr_pkg::FREEZE_BIT] <= mclr_pkg::CODE_PROTECT_RST[mclr_pkg::FREEZE_BIT];
      end else if (key_ok) begin
         protect_r[mclr_pkg::FREEZE_BIT] <= 1'b0;
      end else if (wr_protect && reg_wdata_in[mclr_pkg::FREEZE_BIT]) begin
         protect_r[mclr_pkg::FREEZE_BIT] <= 1'b1;
      end
   end

   // Override and paired mode are locked while the store is frozen.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         protect_r[mclr_pkg::OVERRIDE_BIT] <= mclr_pkg::CODE_PROTECT_RST[mclr_pkg::OVERRIDE_BIT];
         protect_r[mclr_pkg::PAIRED_BIT]   <= mclr_pkg::CODE_PROTECT_RST[mclr_pkg::PAIRED_BIT];
      end else if (wr_protect && !protect_r[mclr_pkg::FREEZE_BIT]) begin
         protect_r[mclr_pkg::OVERRIDE_BIT] <= reg_wdata_in[mclr_pkg::OVERRIDE_BIT];
         protect_r[mclr_pkg::PAIRED_BIT]   <= reg_wdata_in[mclr_pkg::PAIRED_BIT];
      end
   end

   // Alert enable is never locked.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         protect_r[mclr_pkg::ALERT_EN_BIT] <= mclr_pkg::CODE_PROTECT_RST[mclr_pkg::ALERT_EN_BIT];
      end else if (wr_protect) begin
         protect_r[mclr_pkg::ALERT_EN_BIT] <= reg_wdata_in[mclr_pkg::ALERT_EN_BIT];
      end
   end

   // Edge detector for the freeze bit; it starts the digest engine.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         freeze_d_r <= 1'b0;
      end else begin
         freeze_d_r <= protect_r[mclr_pkg::FREEZE_BIT];
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         digest_start_out <= 1'b0;
      end else begin
         digest_start_out <= freeze_rise;
      end
   end

   mclr_digest_check u_check (
      .mclk_in        (mclk_in),
      .rst_n_in       (rst_n_in),
      .done_in        (digest_done_in),
      .computed_in    (digest_value_in),
      .expect_high_in (digest_high_r),
      .expect_low_in  (digest_low_r),
      .result_out     (chk_result)
   );

   // Run permit ignores host writes; only a digest verdict sets it.
   // A failure with override set still lets the cores run.
   // Releasing the freeze drops the permit so new code is checked again.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         protect_r[mclr_pkg::RUN_PERMIT_BIT] <= mclr_pkg::CODE_PROTECT_RST[mclr_pkg::RUN_PERMIT_BIT];
      end else if (chk_result == mclr_pkg::MCLR_CHK_PASS) begin
         protect_r[mclr_pkg::RUN_PERMIT_BIT] <= 1'b1;
      end else if (chk_result == mclr_pkg::MCLR_CHK_FAIL) begin
         protect_r[mclr_pkg::RUN_PERMIT_BIT] <= protect_r[mclr_pkg::OVERRIDE_BIT];
      end else if (key_ok) begin
         protect_r[mclr_pkg::RUN_PERMIT_BIT] <= 1'b0;
      end
   end

   // Mismatch flag: a failure in the same cycle as a freeze rise wins.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         protect_r[mclr_pkg::MISMATCH_BIT] <= mclr_pkg::CODE_PROTECT_RST[mclr_pkg::MISMATCH_BIT];
      end else if (chk_result == mclr_pkg::MCLR_CHK_FAIL) begin
         protect_r[mclr_pkg::MISMATCH_BIT] <= 1'b1;
      end else if (freeze_rise) begin
         protect_r[mclr_pkg::MISMATCH_BIT] <= 1'b0;
      end
   end

   // Unused positions of the protection register stay at their reset value.
   // They are kept procedural so no bit of the register mixes driver kinds.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         protect_r[2]    <= mclr_pkg::CODE_PROTECT_RST[2];
         protect_r[15:7] <= mclr_pkg::CODE_PROTECT_RST[15:7];
      end else begin
         protect_r[2]    <= mclr_pkg::CODE_PROTECT_RST[2];
         protect_r[15:7] <= mclr_pkg::CODE_PROTECT_RST[15:7];
      end
   end

   // Remembers a failed check so the interrupt holds until the next freeze.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fail_seen_r <= 1'b0;
      end else if (chk_result == mclr_pkg::MCLR_CHK_FAIL) begin
         fail_seen_r <= 1'b1;
      end else if (freeze_rise) begin
         fail_seen_r <= 1'b0;
      end
   end

   // Expected digest halves, locked while frozen.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         digest_high_r <= mclr_pkg::DIGEST_RST;
         digest_low_r  <= mclr_pkg::DIGEST_RST;
      end else if (reg_wr_in && !protect_r[mclr_pkg::FREEZE_BIT]) begin
         if (reg_addr_in == mclr_pkg::DIGEST_HIGH_OFS) begin
            digest_high_r <= reg_wdata_in;
         end
         if (reg_addr_in == mclr_pkg::DIGEST_LOW_OFS) begin
            digest_low_r <= reg_wdata_in;
         end
      end
   end

   // Core command field, host written at any time.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         command_r <= mclr_pkg::FIELD_RST;
      end else if (wr_command) begin
         command_r <= reg_wdata_in[mclr_pkg::CMD_LSB +: mclr_pkg::FIELD_W];
      end
   end

   mclr_dual_field u_dual (
      .mclk_in        (mclk_in),
      .rst_n_in       (rst_n_in),
      .status_role_in (dual_role_status_in),
      .host_wr_in     (wr_command),
      .host_data_in   (reg_wdata_in[mclr_pkg::DUAL_LSB +: mclr_pkg::FIELD_W]),
      .core_set_in    (core_set_bit_in),
      .core_clr_in    (core_clr_bit_in),
      .core_idx_in    (core_bit_index_in),
      .field_out      (dual_role_out)
   );

   // Read data is registered; unmapped addresses read as zero.
   always_comb begin
      case (reg_addr_in)
         mclr_pkg::CODE_PROTECT_OFS:  rdata_nxt = protect_r;
         mclr_pkg::CORE0_COMMAND_OFS: rdata_nxt = {dual_role_out, command_r};
         mclr_pkg::DIGEST_HIGH_OFS:   rdata_nxt = digest_high_r;
         mclr_pkg::DIGEST_LOW_OFS:    rdata_nxt = digest_low_r;
         default:                     rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out  <= 16'h0000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= rdata_nxt;
         end
      end
   end

   // Program store write gate.
   assign store_wr_grant_out  = store_wr_req_in && !protect_r[mclr_pkg::FREEZE_BIT];
   assign store_wr_reject_out = store_wr_req_in && protect_r[mclr_pkg::FREEZE_BIT];

   // Core-facing outputs.
   assign core_command_out      = command_r;
   assign core_run_out          = protect_r[mclr_pkg::RUN_PERMIT_BIT];
   assign paired_core_mode_out  = protect_r[mclr_pkg::PAIRED_BIT];
   // Only a warning line; the cores themselves enforce the restriction.
   assign access_restricted_out = protect_r[mclr_pkg::PAIRED_BIT]
                                  && (core_clock_divider_in < mclr_pkg::DIVIDER_MIN_FULL);
   assign irq_out               = protect_r[mclr_pkg::ALERT_EN_BIT] && fail_seen_r;
endmodule
`default_nettype wire

// ### tb/mclr_digest_model.sv
// Behavioural digest engine facing the register block.
// Answers each start pulse after lat_in cycles; lat_in must be at least one.
`timescale 1ns/1ns
`default_nettype none
module mclr_digest_model (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        start_in,
   input  wire logic [31:0] sum_in,
   input  wire logic [7:0]  lat_in,
   output logic             done_out,
   output logic [31:0]      value_out
);
   logic [7:0] cnt_r;
   // The value is only meaningful with done, so it toggles otherwise.
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r     <= 8'h00;
         done_out  <= 1'b0;
         value_out <= 32'h0000_0000;
      end else begin
         done_out  <= 1'b0;
         value_out <= ~value_out;
         if (start_in) begin
            cnt_r <= lat_in;
         end else if (cnt_r == 8'h01) begin
            cnt_r     <= 8'h00;
            done_out  <= 1'b1;
            value_out <= sum_in;
         end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/mclr_monitor.sv
// Checker for the code protection and core command registers.
// Sees only the top module ports; bound to mclr_top below.
`timescale 1ns/1ns
`default_nettype none
module mclr_monitor (
   // Clock, reset and host port
   input wire logic        mclk_in,
   input wire logic        rst_n_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [9:0]  reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic        reg_rvalid_out,
   input wire logic        key_wr_in,
   input wire logic [15:0] key_data_in,
   // Store gate and digest
   input wire logic        store_wr_req_in,
   input wire logic        store_wr_grant_out,
   input wire logic        store_wr_reject_out,
   input wire logic        digest_start_out,
   input wire logic        digest_done_in,
   // Microcore side
   input wire logic        dual_role_status_in,
   input wire logic        core_set_bit_in,
   input wire logic        core_clr_bit_in,
   input wire logic [2:0]  core_bit_index_in,
   input wire logic [3:0]  core_clock_divider_in,
   input wire logic [7:0]  core_command_out,
   input wire logic [7:0]  dual_role_out,
   input wire logic        core_run_out,
   input wire logic        paired_core_mode_out,
   input wire logic        access_restricted_out,
   input wire logic        irq_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // Saturating age of the last digest engine done pulse, so rises can be tied to it.
   logic [3:0] since_done_r;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         since_done_r <= 4'hf;
      end else if (digest_done_in) begin
         since_done_r <= 4'h0;
      end else if (since_done_r != 4'hf) begin
         since_done_r <= since_done_r + 4'h1;
      end
   end
   store_gate_a: assert property (store_wr_req_in |-> store_wr_grant_out != store_wr_reject_out)
      else $error("store gate not exclusive");
   gate_idle_a: assert property (!store_wr_req_in |-> !store_wr_grant_out && !store_wr_reject_out)
      else $error("store gate active without request");
   freeze_start_a: assert property (reg_wr_in && reg_addr_in == 10'h100 && reg_wdata_in[4]
      && store_wr_grant_out |-> ##[1:2] digest_start_out)
      else $error("freeze did not start digest");
   permit_cause_a: assert property ($rose(core_run_out) |-> since_done_r <= 4'h3)
      else $error("run permit rose without verdict");
   irq_cause_a: assert property ($rose(irq_out) |-> since_done_r <= 4'h3)
      else $error("interrupt rose without verdict");
   key_clear_a: assert property (key_wr_in && key_data_in == mclr_pkg::RELEASE_KEY
      && since_done_r > 4'h4 && !digest_done_in |=> !core_run_out && !store_wr_reject_out)
      else $error("release key did not unfreeze");
   restrict_a: assert property (access_restricted_out == (paired_core_mode_out && core_clock_divider_in < 4'h3))
      else $error("access restriction wrong");
   cmd_write_a: assert property (reg_wr_in && reg_addr_in == 10'h101
      |=> core_command_out == $past(reg_wdata_in[7:0]))
      else $error("command field not written");
   status_hold_a: assert property (dual_role_status_in && !core_set_bit_in && !core_clr_bit_in
      |=> dual_role_out == $past(dual_role_out))
      else $error("status field changed by host");
   status_set_a: assert property (core_set_bit_in && dual_role_status_in
      |=> dual_role_out[$past(core_bit_index_in)])
      else $error("status bit not set");
   read_valid_a: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read not answered");
endmodule
bind mclr_top mclr_monitor mon (.mclk_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
   .reg_rvalid_out, .key_wr_in, .key_data_in, .store_wr_req_in, .store_wr_grant_out, .store_wr_reject_out,
   .digest_start_out, .digest_done_in, .dual_role_status_in, .core_set_bit_in, .core_clr_bit_in,
   .core_bit_index_in, .core_clock_divider_in, .core_command_out, .dual_role_out, .core_run_out,
   .paired_core_mode_out, .access_restricted_out, .irq_out);
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the code protection and core command registers.
// Inputs change on the falling edge; a digest engine model answers starts.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        mclk_in, rst_n_in, reg_wr_in, reg_rd_in, reg_rvalid_out, key_wr_in;
   logic [9:0]  reg_addr_in;
   logic [15:0] reg_wdata_in, reg_rdata_out, key_data_in;
   logic        store_wr_req_in, store_wr_grant_out, store_wr_reject_out;
   logic        digest_start_out, digest_done_in;
   logic [31:0] digest_value_in, sum;
   logic        dual_role_status_in, core_set_bit_in, core_clr_bit_in;
   logic [2:0]  core_bit_index_in;
   logic [3:0]  core_clock_divider_in;
   logic [7:0]  core_command_out, dual_role_out;
   logic        core_run_out, paired_core_mode_out, access_restricted_out, irq_out;
   int          err_total, total_checks, cycles;
   mclr_top dut (.mclk_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
      .reg_rvalid_out, .key_wr_in, .key_data_in, .store_wr_req_in, .store_wr_grant_out, .store_wr_reject_out,
      .digest_start_out, .digest_done_in, .digest_value_in, .dual_role_status_in, .core_set_bit_in,
      .core_clr_bit_in, .core_bit_index_in, .core_clock_divider_in, .core_command_out, .dual_role_out,
      .core_run_out, .paired_core_mode_out, .access_restricted_out, .irq_out);
   mclr_digest_model eng (.mclk_in, .rst_n_in, .start_in(digest_start_out), .sum_in(sum), .lat_in(8'h10),
      .done_out(digest_done_in), .value_out(digest_value_in));
   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   task automatic complete_run;
      if (err_total == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         complete_run();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(negedge mclk_in);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge mclk_in);
      reg_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [15:0] e, input string n);
      @(negedge mclk_in);
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      @(negedge mclk_in);
      reg_rd_in = 1'b0;
      chk("rvalid", 1'b1, reg_rvalid_out);
      chk(n, e, reg_rdata_out);
   endtask
   task automatic key(input logic [15:0] d);
      @(negedge mclk_in);
      key_wr_in = 1'b1;
      key_data_in = d;
      @(negedge mclk_in);
      key_wr_in = 1'b0;
   endtask
   task automatic bit_op(input logic set, input logic [2:0] idx);
      @(negedge mclk_in);
      core_set_bit_in = set;
      core_clr_bit_in = !set;
      core_bit_index_in = idx;
      @(negedge mclk_in);
      core_set_bit_in = 1'b0;
      core_clr_bit_in = 1'b0;
   endtask
   // Waits for the engine's done pulse, then lets the verdict settle.
   task automatic wait_verdict;
      for (int i = 0; i < 100 && digest_done_in !== 1'b1; i++) @(negedge mclk_in);
      chk("digest done", 1'b1, digest_done_in);
      repeat (4) @(negedge mclk_in);
   endtask
   initial begin
      {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, key_wr_in, key_data_in, store_wr_req_in,
         dual_role_status_in, core_set_bit_in, core_clr_bit_in, core_bit_index_in, core_clock_divider_in} = '0;
      {sum, err_total, total_checks, cycles} = '0;
      repeat (8) @(posedge mclk_in);
      @(negedge mclk_in);
      chk("grant idle", 1'b0, store_wr_grant_out);
      rst_n_in = 1'b1;
      store_wr_req_in = 1'b1;
      rd(10'h100, 16'h0000, "protect");
      rd(10'h101, 16'h0000, "command");
      chk("grant", 1'b1, store_wr_grant_out);
      wr(10'h100, 16'hffef);
      rd(10'h100, 16'h004a, "protect mask");
      chk("paired", 1'b1, paired_core_mode_out);
      for (int d = 0; d < 5; d++) begin
         @(negedge mclk_in);
         core_clock_divider_in = d[3:0];
         #1 chk("restricted", d < 3, access_restricted_out);
      end
      wr(10'h101, 16'ha5c3);
      rd(10'h101, 16'ha5c3, "command");
      chk("cmd out", 8'hc3, core_command_out);
      dual_role_status_in = 1'b1;
      wr(10'h101, 16'h1234);
      chk("cmd out", 8'h34, core_command_out);
      chk("dual out", 8'ha5, dual_role_out);
      bit_op(1'b1, 3'h1);
      chk("dual set", 8'ha7, dual_role_out);
      bit_op(1'b0, 3'h0);
      rd(10'h101, 16'ha634, "command");
      wr(10'h100, 16'h0002);
      wr(10'h108, 16'h1234);
      wr(10'h109, 16'h5678);
      sum = 32'h1234_5678;
      wr(10'h100, 16'h0012);
      chk("reject", 1'b1, store_wr_reject_out);
      @(negedge mclk_in);
      chk("start", 1'b1, digest_start_out);
      chk("run early", 1'b0, core_run_out);
      wr(10'h108, 16'hffff);
      wr(10'h100, 16'h0002);
      wait_verdict;
      chk("run", 1'b1, core_run_out);
      chk("irq pass", 1'b0, irq_out);
      rd(10'h100, 16'h0032, "protect pass");
      key(16'h0000);
      chk("reject kept", 1'b1, store_wr_reject_out);
      key(mclr_pkg::RELEASE_KEY);
      chk("grant back", 1'b1, store_wr_grant_out);
      chk("run cleared", 1'b0, core_run_out);
      wr(10'h100, 16'h0042);
      sum = 32'h0000_0000;
      wr(10'h100, 16'h0052);
      wait_verdict;
      chk("run override", 1'b1, core_run_out);
      chk("irq fail", 1'b1, irq_out);
      rd(10'h100, 16'h0073, "protect fail");
      key(mclr_pkg::RELEASE_KEY);
      wr(10'h100, 16'h0002);
      wr(10'h100, 16'h0012);
      rd(10'h100, 16'h0012, "refreeze");
      chk("irq cleared", 1'b0, irq_out);
      wait_verdict;
      chk("run halted", 1'b0, core_run_out);
      rd(10'h100, 16'h0013, "protect halt");
      chk("irq halt", 1'b1, irq_out);
      wr(10'h100, 16'h0010);
      chk("irq masked", 1'b0, irq_out);
      complete_run();
   end
endmodule
`default_nettype wire
